//--- rtl/lpmc_top.sv
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Low-power mode controller: stop, wake-up timer and RC watchdog modes
module lpmc_top (
  input  wire logic       REF_CLK_I,
  input  wire logic       RESET_I,
  // Register port
  input  wire logic [1:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic [7:0]      RDATA_O,
  // Core side
  input  wire logic       STOP_EXEC_I,
  input  wire logic       DI_EXEC_I,
  input  wire logic       EI_EXEC_I,
  input  wire logic [15:0] NEXT_PC_I,
  input  wire logic       EXT_IRQ_A_I,
  input  wire logic       EXT_IRQ_B_I,
  input  wire logic       RC_WDOG_EXPIRE_I,
  input  wire logic [7:0] PORT_DATA_I,
  input  wire logic [7:0] PORT_DIR_I,
  output logic            MAIN_OSC_EN_O,
  output logic            RC_OSC_EN_O,
  output logic            CORE_CLK_EN_O,
  output logic            PRESCALE_2048_O,
  output logic            WAKE_OVERFLOW_O,
  output logic [15:0]     RESUME_PC_O,
  output logic            RESUME_O,
  output logic            IRQ_ACCEPT_O,
  output logic            WDOG_VECTOR_O,
  output logic            INT_RESET_O,
  output logic [7:0]      PORT_OUT_O,
  output logic [7:0]      PORT_OE_O,
  output logic            IRQ_MASK_O
);

  typedef struct packed {
    lpmc_pkg::lpmc_state_t  state;
    lpmc_pkg::lpmc_resume_t pend;
    logic [7:0]             clk_ctl;
    logic [7:0]             ien_high;
    logic [7:0]             wake_period;
    logic [7:0]             wake_cnt;
    logic [10:0]            prescale;
    logic                   tick_2048;
    logic                   wake_ovf;
    logic                   irq_mask;
    logic [15:0]            resume_pc;
    logic                   resume;
    logic                   accept;
    logic                   wdog_vec;
    logic                   int_rst;
    logic                   wdog_src;
    logic                   stab_start;
    logic [7:0]             port_out;
    logic [7:0]             port_oe;
    logic [7:0]             rdata;
  } lpmc_state_s_t;

  lpmc_state_s_t s_reg;
  lpmc_state_s_t s_next;

  logic       stab_done;
  logic       ext_irq;

  // Either external interrupt pin may release a mode
  assign ext_irq = EXT_IRQ_A_I | EXT_IRQ_B_I;

  // Status byte: state code, wake overflow and interrupt mask for software readback
  function automatic logic [7:0] lpmc_status(input lpmc_state_s_t s);
    lpmc_status = {3'h0, s.irq_mask, s.wake_ovf, 3'(s.state)};
  endfunction

  // Decode of the mode that a stop instruction would enter
  function automatic lpmc_pkg::lpmc_state_t lpmc_mode(input logic [7:0] ctl);
    if (ctl[lpmc_pkg::BIT_TIMER_RESUME]) begin
      lpmc_mode = lpmc_pkg::LPMC_WAKE_TIMER;
    end else if (ctl[lpmc_pkg::BIT_RC_WDOG_SEL]) begin
      lpmc_mode = lpmc_pkg::LPMC_RC_WDOG;
    end else begin
      lpmc_mode = lpmc_pkg::LPMC_STOP;
    end
  endfunction

  // Resume kind on an interrupt release, chosen by the global mask
  function automatic lpmc_pkg::lpmc_resume_t lpmc_irq_resume(input logic mask);
    lpmc_irq_resume = mask ? lpmc_pkg::LPMC_RES_VECTOR : lpmc_pkg::LPMC_RES_NEXT;
  endfunction

  // Next-state logic; all state lives in one struct
  always_comb begin
    s_next            = s_reg;
    s_next.resume     = 1'b0;
    s_next.accept     = 1'b0;
    s_next.wdog_vec   = 1'b0;
    s_next.int_rst    = 1'b0;
    s_next.stab_start = 1'b0;
    s_next.tick_2048  = 1'b0;
    s_next.wake_ovf   = 1'b0;
    s_next.rdata      = 8'h00;

    // Global mask follows the enable and disable instructions
    if (DI_EXEC_I) begin
      s_next.irq_mask = 1'b0;
    end else if (EI_EXEC_I) begin
      s_next.irq_mask = 1'b1;
    end

    // Register writes are taken only while the core runs
    if (WR_I && (s_reg.state == lpmc_pkg::LPMC_RUN)) begin
      unique case (ADDR_I)
        lpmc_pkg::OFF_CLOCK_CONTROL:   s_next.clk_ctl     = WDATA_I;
        lpmc_pkg::OFF_IRQ_ENABLE_HIGH: s_next.ien_high    = WDATA_I;
        lpmc_pkg::OFF_WAKE_PERIOD:     s_next.wake_period = WDATA_I;
        lpmc_pkg::OFF_STATUS: begin
        end
      endcase
    end

    // Read data stands in the cycle after the strobe
    if (RD_I) begin
      unique case (ADDR_I)
        lpmc_pkg::OFF_CLOCK_CONTROL:   s_next.rdata = s_reg.clk_ctl;
        lpmc_pkg::OFF_IRQ_ENABLE_HIGH: s_next.rdata = s_reg.ien_high;
        lpmc_pkg::OFF_WAKE_PERIOD:     s_next.rdata = s_reg.wake_period;
        lpmc_pkg::OFF_STATUS:          s_next.rdata = lpmc_status(s_reg);
      endcase
    end

    // Prescaler runs in run and wake-up timer modes only
    if ((s_reg.state == lpmc_pkg::LPMC_RUN) || (s_reg.state == lpmc_pkg::LPMC_WAKE_TIMER)) begin
      if (s_reg.prescale == lpmc_pkg::PRESCALE_LAST) begin
        s_next.prescale  = 11'h000;
        s_next.tick_2048 = 1'b1;
      end else begin
        s_next.prescale = s_reg.prescale + 11'h001;
      end
    end

    // Wake counter counts divide-by-2048 ticks up to its period register
    if (s_reg.tick_2048) begin
      if (s_reg.wake_cnt == s_reg.wake_period) begin
        s_next.wake_cnt = 8'h00;
        s_next.wake_ovf = 1'b1;
      end else begin
        s_next.wake_cnt = s_reg.wake_cnt + 8'h01;
      end
    end

    unique case (s_reg.state)
      lpmc_pkg::LPMC_RUN: begin
        // Ports keep driving from the latest data and direction
        s_next.port_out = PORT_DATA_I;
        s_next.port_oe  = PORT_DIR_I;
        if (STOP_EXEC_I) begin
          s_next.resume_pc = NEXT_PC_I;
          s_next.state     = lpmc_mode(s_reg.clk_ctl);
          s_next.wake_cnt  = 8'h00;
        end
      end
      lpmc_pkg::LPMC_STOP: begin
        // Only an external interrupt ends it; wake overflow cannot tick here
        if (ext_irq) begin
          s_next.pend       = lpmc_irq_resume(s_reg.irq_mask);
          s_next.stab_start = 1'b1;
          s_next.wdog_src   = 1'b0;
          s_next.state      = lpmc_pkg::LPMC_STABILISE;
        end
      end
      lpmc_pkg::LPMC_WAKE_TIMER: begin
        // Oscillator never stopped, so resume at once
        if (ext_irq || s_reg.wake_ovf) begin
          s_next.resume = 1'b1;
          s_next.accept = s_reg.irq_mask;
          s_next.state  = lpmc_pkg::LPMC_RUN;
        end
      end
      lpmc_pkg::LPMC_RC_WDOG: begin
        if (ext_irq) begin
          s_next.pend       = lpmc_irq_resume(s_reg.irq_mask);
          s_next.stab_start = 1'b1;
          s_next.wdog_src   = 1'b0;
          s_next.state      = lpmc_pkg::LPMC_STABILISE;
        end else if (RC_WDOG_EXPIRE_I) begin
          if (s_reg.clk_ctl[lpmc_pkg::BIT_WDOG_RESET_SEL]) begin
            s_next.pend = lpmc_pkg::LPMC_RES_RESET;
          end else if (s_reg.irq_mask && s_reg.ien_high[lpmc_pkg::BIT_WDOG_IRQ_ENABLE]) begin
            s_next.pend = lpmc_pkg::LPMC_RES_VECTOR;
          end else begin
            s_next.pend = lpmc_pkg::LPMC_RES_NEXT;
          end
          s_next.stab_start = 1'b1;
          s_next.wdog_src   = 1'b1;
          s_next.state      = lpmc_pkg::LPMC_STABILISE;
        end
      end
      lpmc_pkg::LPMC_STABILISE: begin
        // Core stays frozen until the interval counter overflows
        if (stab_done) begin
          s_next.resume = (s_reg.pend != lpmc_pkg::LPMC_RES_RESET);
          s_next.accept = (s_reg.pend == lpmc_pkg::LPMC_RES_VECTOR);
          // An external wake must not enter the watchdog routine, so the source is kept
          s_next.wdog_vec = (s_reg.pend == lpmc_pkg::LPMC_RES_VECTOR) && s_reg.wdog_src;
          s_next.int_rst  = (s_reg.pend == lpmc_pkg::LPMC_RES_RESET);
          s_next.pend     = lpmc_pkg::LPMC_RES_NONE;
          s_next.wdog_src = 1'b0;
          s_next.state    = lpmc_pkg::LPMC_RUN;
        end
      end
      // Unused state codes fall back to run rather than lock the core out
      default: begin
        s_next.state = lpmc_pkg::LPMC_RUN;
      end
    endcase

    // Internal watchdog reset reinitialises control registers only
    if (s_reg.int_rst) begin
      s_next.clk_ctl     = lpmc_pkg::RST_CLOCK_CONTROL;
      s_next.ien_high    = lpmc_pkg::RST_IRQ_ENABLE_HIGH;
      s_next.wake_period = lpmc_pkg::RST_WAKE_PERIOD;
      s_next.irq_mask    = 1'b0;
    end
  end

  // Hardware reset clears control state; RAM is outside this block
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      s_reg             <= '0;
      s_reg.state       <= lpmc_pkg::LPMC_RUN;
      s_reg.pend        <= lpmc_pkg::LPMC_RES_NONE;
      s_reg.clk_ctl     <= lpmc_pkg::RST_CLOCK_CONTROL;
      s_reg.ien_high    <= lpmc_pkg::RST_IRQ_ENABLE_HIGH;
      s_reg.wake_period <= lpmc_pkg::RST_WAKE_PERIOD;
    end else begin
      s_reg <= s_next;
    end
  end

  // Stabilisation counter; prescale ratio comes from the low clock control bits
  lpmc_stab_counter u_stab (
    .REF_CLK_I  (REF_CLK_I),
    .RESET_I    (RESET_I),
    .start_i    (s_reg.stab_start),
    .prescale_i ({4'h0, s_reg.clk_ctl[3:0]}),
    .done_o     (stab_done),
    .count_o    ()
  );

  // Oscillator and clock gating per mode
  assign MAIN_OSC_EN_O   = (s_reg.state != lpmc_pkg::LPMC_STOP) &&
                           (s_reg.state != lpmc_pkg::LPMC_RC_WDOG);
  assign RC_OSC_EN_O     = (s_reg.state == lpmc_pkg::LPMC_RC_WDOG);
  assign CORE_CLK_EN_O   = (s_reg.state == lpmc_pkg::LPMC_RUN);
  assign PRESCALE_2048_O = s_reg.tick_2048;
  assign WAKE_OVERFLOW_O = s_reg.wake_ovf;
  assign RESUME_PC_O     = s_reg.resume_pc;
  assign RESUME_O        = s_reg.resume;
  assign IRQ_ACCEPT_O    = s_reg.accept;
  assign WDOG_VECTOR_O   = s_reg.wdog_vec;
  assign INT_RESET_O     = s_reg.int_rst;
  assign PORT_OUT_O      = s_reg.port_out;
  assign PORT_OE_O       = s_reg.port_oe;
  assign IRQ_MASK_O      = s_reg.irq_mask;
  assign RDATA_O         = s_reg.rdata;

endmodule

//--- rtl/lpmc_pkg.sv
// Contract
// - Stop instruction with select bits 00 enters stop mode.
// - Stop mode halts main oscillator and freezes all state.
// - Port pins keep driving their levels in every power-saving mode.
// - Program counter holds the address after the stop instruction.
// - Stop mode ends only on reset or either external interrupt.
// - Reset reinitialises control registers; interrupt release keeps everything.
// - Interrupt mask 1 gives normal acceptance; 0 resumes after stop.
// - External-interrupt release from stop waits for interval counter 00 to FF.
// - Stop with timer-resume select 1 enters wake-up timer mode, oscillator on.
// - Wake-up timer mode runs only the divide-by-2048 prescaler and wake counter.
// - Wake interval is set by the wake counter period register.
// - Wake-up timer mode ends on reset, wake counter overflow or external interrupt.
// - Release from wake-up timer mode needs no stabilisation wait.
// - Stop with select bits 01 enters RC watchdog mode.
// - RC watchdog mode halts main oscillator, RC oscillator keeps running.
// - Watchdog release vectors or raises internal reset per watchdog-reset select.
// - External-interrupt release from RC watchdog mode waits the stabilisation count.
// - Interrupt mask is cleared by disable and set by enable instruction.
package lpmc_pkg;

  // Register offsets on the plain register port
  localparam logic [1:0] OFF_CLOCK_CONTROL   = 2'h0;
  localparam logic [1:0] OFF_IRQ_ENABLE_HIGH = 2'h1;
  localparam logic [1:0] OFF_WAKE_PERIOD     = 2'h2;
  localparam logic [1:0] OFF_STATUS          = 2'h3;

  // Clock control register fields
  localparam int unsigned BIT_WDOG_RESET_SEL  = 4;
  localparam int unsigned BIT_RC_WDOG_SEL     = 5;
  localparam int unsigned BIT_TIMER_RESUME    = 6;
  // Interrupt enable high field
  localparam int unsigned BIT_WDOG_IRQ_ENABLE = 3;

  // Reset values
  localparam logic [7:0] RST_CLOCK_CONTROL   = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE_HIGH = 8'h00;
  localparam logic [7:0] RST_WAKE_PERIOD     = 8'hff;

  // Timing: prescaler tap for the wake counter and interval counter length
  localparam int unsigned PRESCALE_DIV        = 2048;
  localparam logic [10:0] PRESCALE_LAST       = 11'(PRESCALE_DIV - 1);
  localparam logic [7:0]  STAB_COUNT_LAST     = 8'hff;
  localparam logic [7:0]  BIT_PRESCALE_RST    = 8'h00;

  // Operating states
  typedef enum logic [2:0] {
    LPMC_RUN,
    LPMC_STOP,
    LPMC_WAKE_TIMER,
    LPMC_RC_WDOG,
    LPMC_STABILISE
  } lpmc_state_t;

  // Resume kind reported to the core
  typedef enum logic [1:0] {
    LPMC_RES_NONE,
    LPMC_RES_NEXT,
    LPMC_RES_VECTOR,
    LPMC_RES_RESET
  } lpmc_resume_t;

endpackage

//--- rtl/lpmc_stab_counter.sv
`timescale 1ns/1ps
// Oscillator stabilisation counter: counts 00 to FF on prescaler ticks
module lpmc_stab_counter (
  input  wire logic       REF_CLK_I,
  input  wire logic       RESET_I,
  input  wire logic       start_i,
  input  wire logic [7:0] prescale_i,
  output logic            done_o,
  output logic [7:0]      count_o
);

  typedef struct packed {
    logic       busy;
    logic       done;
    logic [7:0] pre;
    logic [7:0] cnt;
  } lpmc_stab_t;

  lpmc_stab_t st_reg;
  lpmc_stab_t st_next;

  // Restart from zero on every start; done pulses one cycle at overflow
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (start_i) begin
      st_next.busy = 1'b1;
      st_next.pre  = 8'h00;
      st_next.cnt  = 8'h00;
    end else if (st_reg.busy) begin
      if (st_reg.pre >= prescale_i) begin
        st_next.pre = 8'h00;
        if (st_reg.cnt == lpmc_pkg::STAB_COUNT_LAST) begin
          st_next.busy = 1'b0;
          st_next.done = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt + 8'h01;
        end
      end else begin
        st_next.pre = st_reg.pre + 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done_o  = st_reg.done;
  assign count_o = st_reg.cnt;

endmodule

//--- sim/lpmc_properties.sv
`timescale 1ns/1ps
// Port-level timing checks bound onto the controller top
module lpmc_props (
  input wire logic        REF_CLK_I,
  input wire logic        RESET_I,
  input wire logic        STOP_EXEC_I,
  input wire logic        DI_EXEC_I,
  input wire logic        EI_EXEC_I,
  input wire logic [15:0] NEXT_PC_I,
  input wire logic        EXT_IRQ_A_I,
  input wire logic        EXT_IRQ_B_I,
  input wire logic        MAIN_OSC_EN_O,
  input wire logic        RC_OSC_EN_O,
  input wire logic        CORE_CLK_EN_O,
  input wire logic        WAKE_OVERFLOW_O,
  input wire logic [15:0] RESUME_PC_O,
  input wire logic        RESUME_O,
  input wire logic        IRQ_ACCEPT_O,
  input wire logic        WDOG_VECTOR_O,
  input wire logic        INT_RESET_O,
  input wire logic [7:0]  PORT_OUT_O,
  input wire logic [7:0]  PORT_OE_O,
  input wire logic        IRQ_MASK_O
);
  default clocking dck @(posedge REF_CLK_I);
  endclocking
  default disable iff (RESET_I);

  // Mode entry and the captured return address
  stop_entry_a:
    assert property (STOP_EXEC_I && CORE_CLK_EN_O |=> !CORE_CLK_EN_O && RESUME_PC_O == $past(NEXT_PC_I))
    else $error("stop entry or return address wrong");
  // Pins stay put once asleep; one cycle of slack for the entry edge
  ports_held_a:
    assert property (!CORE_CLK_EN_O && !$past(CORE_CLK_EN_O) |-> $stable(PORT_OUT_O) && $stable(PORT_OE_O))
    else $error("port levels moved while asleep");
  // Only an external request wakes stop mode
  stop_hold_a:
    assert property (!CORE_CLK_EN_O && !MAIN_OSC_EN_O && !RC_OSC_EN_O && !EXT_IRQ_A_I && !EXT_IRQ_B_I
                     |=> !CORE_CLK_EN_O && !MAIN_OSC_EN_O)
    else $error("stop mode left without a release source");
  // Oscillator restarts and the core stays held for the first 8 cycles of the interval count
  stab_wait_a:
    assert property (!CORE_CLK_EN_O && !MAIN_OSC_EN_O && (EXT_IRQ_A_I || EXT_IRQ_B_I)
                     |=> (MAIN_OSC_EN_O && !RESUME_O) [*8])
    else $error("no stabilisation wait after external wake");
  // Cycles since an external wake out of a halted oscillator; zero when none is pending
  logic        stab_trig;
  logic [12:0] stab_cyc_reg;
  assign stab_trig = !CORE_CLK_EN_O && !MAIN_OSC_EN_O && (EXT_IRQ_A_I || EXT_IRQ_B_I);
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      stab_cyc_reg <= 13'h0000;
    end else if (stab_trig) begin
      stab_cyc_reg <= 13'h0001;
    end else if (RESUME_O || INT_RESET_O) begin
      stab_cyc_reg <= 13'h0000;
    end else if ((stab_cyc_reg != 13'h0000) && (stab_cyc_reg != 13'h1fff)) begin
      stab_cyc_reg <= stab_cyc_reg + 13'h0001;
    end
  end
  // Resume no earlier than a full 00 to FF count
  stab_early_a:
    assert property (RESUME_O && (stab_cyc_reg != 13'h0000) |-> stab_cyc_reg >= 13'h00ff)
    else $error("stabilisation count cut short");
  // Slowest prescale takes 16 cycles a step, so 4100 cycles cover every setting
  stab_late_a:
    assert property (stab_cyc_reg <= 13'h1004)
    else $error("stabilisation count never finished");
  wake_release_a:
    assert property (WAKE_OVERFLOW_O && MAIN_OSC_EN_O && !CORE_CLK_EN_O |-> ##[0:2] RESUME_O)
    else $error("wake overflow did not resume promptly");
  accept_mask_a:
    assert property (RESUME_O && !WDOG_VECTOR_O |-> IRQ_ACCEPT_O == IRQ_MASK_O)
    else $error("acceptance disagrees with the mask");
  mask_update_a:
    assert property ((DI_EXEC_I || EI_EXEC_I) && CORE_CLK_EN_O |=> IRQ_MASK_O == !$past(DI_EXEC_I))
    else $error("mask not updated by enable or disable");
  int_reset_a:
    assert property (INT_RESET_O |-> !RESUME_O && !WDOG_VECTOR_O)
    else $error("internal reset mixed with a resume");
endmodule

bind lpmc_top lpmc_props u_lpmc_props (.*);

//--- sim/lpmc_core_model.sv
`timescale 1ns/1ps
// Core stand-in: issues stop instructions and the address that follows them
module lpmc_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire logic        req_i,
  input  wire logic [15:0] pc_i,
  output logic             stop_o,
  output logic [15:0]      pc_o
);
  logic [1:0] nop_cnt;

  // Two idle slots follow every stop, so a second stop cannot crowd the first
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stop_o  <= 1'b0;
      pc_o    <= 16'h0000;
      nop_cnt <= 2'h0;
    end else begin
      stop_o <= 1'b0;
      pc_o   <= ~pc_o; // Address is only meaningful with the stop pulse
      if (nop_cnt != 2'h0 && run_i) begin
        nop_cnt <= nop_cnt - 2'h1;
      end else if (req_i && run_i && nop_cnt == 2'h0) begin
        stop_o  <= 1'b1;
        pc_o    <= pc_i;
        nop_cnt <= 2'h2;
      end
    end
  end
endmodule

//--- sim/lpmc_tb_top.sv
`timescale 1ns/1ps
// Register-port and power-mode sequences with fixed expectations
module lpmc_tb_top;
  logic        REF_CLK_I, RESET_I, WR_I, RD_I, DI_EXEC_I, EI_EXEC_I, STOP_EXEC_I, EXT_IRQ_A_I, EXT_IRQ_B_I;
  logic        RC_WDOG_EXPIRE_I, MAIN_OSC_EN_O, RC_OSC_EN_O, CORE_CLK_EN_O, PRESCALE_2048_O, WAKE_OVERFLOW_O;
  logic        RESUME_O, IRQ_ACCEPT_O, WDOG_VECTOR_O, INT_RESET_O, IRQ_MASK_O;
  logic [1:0]  ADDR_I;
  logic [7:0]  WDATA_I, RDATA_O, PORT_DATA_I, PORT_DIR_I, PORT_OUT_O, PORT_OE_O;
  logic [15:0] NEXT_PC_I, RESUME_PC_O, pc_req;
  logic [5:0]  ev;
  int          n_errors, checks, n, np, t0, gap;

  // Event bits: 0 stop, 1 disable, 2 enable, 3 irq a, 4 irq b, 5 watchdog
  assign {RC_WDOG_EXPIRE_I, EXT_IRQ_B_I, EXT_IRQ_A_I, EI_EXEC_I, DI_EXEC_I} = ev[5:1];

  lpmc_top u_lpmc_top (.*);
  lpmc_core_model u_lpmc_core_model (.clk_i(REF_CLK_I), .rst_i(RESET_I), .run_i(CORE_CLK_EN_O),
    .req_i(ev[0]), .pc_i(pc_req), .stop_o(STOP_EXEC_I), .pc_o(NEXT_PC_I));

  initial begin
    REF_CLK_I = 1'b0;
    forever #20 REF_CLK_I = ~REF_CLK_I;
  end

  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Whole-byte writes only
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge REF_CLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge REF_CLK_I);
    WR_I <= 1'b0;
  endtask
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
    @(posedge REF_CLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge REF_CLK_I);
    RD_I <= 1'b0;
    @(posedge REF_CLK_I);
    chk(RDATA_O, e);
  endtask
  task automatic pulse(input int b);
    @(posedge REF_CLK_I);
    ev[b] <= 1'b1;
    @(posedge REF_CLK_I);
    ev[b] <= 1'b0;
  endtask
  task automatic sleep(input logic [15:0] p);
    pc_req <= p;
    pulse(0);
    repeat (3) @(posedge REF_CLK_I);
  endtask
  // Bounded wait for the core to come back, timing prescaler ticks meanwhile
  task automatic wait_back;
    n = 0;
    np = 0;
    t0 = 0;
    while (!RESUME_O && !INT_RESET_O && n < 20000) begin
      if (PRESCALE_2048_O) begin
        np++;
        gap = n - t0;
        t0 = n;
      end
      @(posedge REF_CLK_I);
      n++;
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog: the sequences need well under 20000 cycles
  initial begin
    repeat (40000) @(posedge REF_CLK_I);
    n_errors++;
    $display("[ERR] %0t run did not finish", $time);
    test_done;
  end

  initial begin
    {RESET_I, WR_I, RD_I, ADDR_I, WDATA_I, PORT_DATA_I, PORT_DIR_I, pc_req, ev} = {1'b1, 50'h0};
    repeat (16) @(posedge REF_CLK_I);
    RESET_I <= 1'b0;
    rd_chk(2'h0, 8'h00);
    rd_chk(2'h1, 8'h00);
    rd_chk(2'h2, 8'hff);
    wr_reg(2'h3, 8'hff);
    rd_chk(2'h3, 8'h00);
    $display("reset test finished");
    // Stop mode, shortest interval prescale, woken by irq a
    pulse(2);
    wr_reg(2'h0, 8'h00);
    PORT_DATA_I <= 8'h5a;
    PORT_DIR_I <= 8'h0f;
    sleep(16'h1234);
    chk({CORE_CLK_EN_O, MAIN_OSC_EN_O, RC_OSC_EN_O, RESUME_PC_O}, {3'b000, 16'h1234});
    rd_chk(2'h3, 8'h11);
    PORT_DATA_I <= 8'ha5;
    wr_reg(2'h0, 8'h40);
    pulse(5);
    repeat (300) @(posedge REF_CLK_I);
    chk({CORE_CLK_EN_O, MAIN_OSC_EN_O, PORT_OUT_O, PORT_OE_O}, {2'b00, 16'h5a0f});
    pulse(3);
    wait_back;
    chk({n > 250, n < 270, IRQ_ACCEPT_O, WDOG_VECTOR_O}, 4'b1110);
    rd_chk(2'h0, 8'h00);
    $display("stop test finished");
    // Wake-up timer mode, interrupts masked
    wr_reg(2'h2, 8'h03);
    wr_reg(2'h0, 8'h4f);
    pulse(1);
    sleep(16'h0200);
    chk({CORE_CLK_EN_O, MAIN_OSC_EN_O, RC_OSC_EN_O}, 3'b010);
    wait_back;
    chk({np >= 2, n < 8200, 16'(gap)}, {2'b11, 16'h0800});
    chk({RESUME_O, IRQ_ACCEPT_O, RESUME_PC_O}, {2'b10, 16'h0200});
    sleep(16'h0300);
    repeat (50) @(posedge REF_CLK_I);
    pulse(4);
    wait_back;
    chk(n <= 3, 1'b1);
    $display("wake timer test finished");
    // RC watchdog mode: vector, then internal reset, then external wake
    pulse(2);
    wr_reg(2'h1, 8'h08);
    wr_reg(2'h0, 8'h20);
    sleep(16'h0400);
    chk({CORE_CLK_EN_O, MAIN_OSC_EN_O, RC_OSC_EN_O}, 3'b001);
    pulse(5);
    wait_back;
    chk({RESUME_O, WDOG_VECTOR_O, INT_RESET_O}, 3'b110);
    pulse(2);
    wr_reg(2'h0, 8'h30);
    sleep(16'h0500);
    pulse(5);
    wait_back;
    chk({RESUME_O, WDOG_VECTOR_O, INT_RESET_O}, 3'b001);
    repeat (3) @(posedge REF_CLK_I);
    rd_chk(2'h0, 8'h00);
    pulse(2);
    wr_reg(2'h1, 8'h08);
    wr_reg(2'h0, 8'h21);
    sleep(16'h0600);
    pulse(3);
    wait_back;
    chk({n > 500, n < 530}, 2'b11);
    chk({RESUME_O, IRQ_ACCEPT_O, WDOG_VECTOR_O}, 3'b110);
    $display("rc watchdog test finished");
    test_done;
  end
endmodule
